/* File: biu_regs.svh */
// Purpose: Timing counts, select indices and field positions of the bus interface unit
// Assumes: 100 MHz mclk, one bus half-phase per mclk cycle
// Notes:   Definitions only; included by the package
`ifndef BIU_REGS_SVH
`define BIU_REGS_SVH

// Clock and timing
`define CLK_PERIOD_NS       10
`define REFRESH_PERIOD_NS   15600
`define REFRESH_CYCLES      ((`REFRESH_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_WAIT_STATES 4'h3
`define DRAM_WAIT_STATES    4'h0
`define REF_CNT_W           11

// Chip select indices
`define NUM_CS              14
`define CS_UPPER            0
`define CS_LOWER            1
`define CS_MID0             2
`define CS_MID1             3
`define CS_MID2             4
`define CS_MID3             5
`define CS_PCS0             6
`define NUM_PCS             8

// Field layout
`define WAIT_W              4
`define ADDR_W              20
`define DATA_W              16
`define DRAM_HALF_W         9
`define KB_LSB              10
`define PCS_BASE_LSB        11
`define PCS_BLOCK_LSB       8

`endif

/* File: biu_pkg.sv */
// Purpose: Types shared by the bus interface unit files
// Assumes: biu_regs.svh holds every constant
// Notes:   State record of the top module is one packed struct
`include "biu_regs.svh"
package biu_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_T1,
		ST_T2,
		ST_T3,
		ST_TW,
		ST_T4
	} bus_state_type;

	typedef logic [`ADDR_W-1:0]  addr_type;
	typedef logic [`DATA_W-1:0]  data_type;
	typedef logic [`WAIT_W-1:0]  wait_type;
	typedef logic [`NUM_CS-1:0]  cs_vec_type;

	typedef struct packed {
		bus_state_type               state;
		logic                        clk_out;
		wait_type                    wait_cnt;
		logic [`REF_CNT_W-1:0]       ref_cnt;
		logic                        ref_pend;
		logic                        cur_dram;
		logic                        cur_refresh;
		logic                        cur_write;
		logic                        cur_rdy_en;
		addr_type                    cur_addr;
		logic                        cur_bhe_n;
		cs_vec_type                  cur_hit;
		cs_vec_type                  written;
		logic                        pins_oe;
		addr_type                    addr_out;
		data_type                    ad_out;
		logic                        ad_oe;
		logic                        ale;
		logic                        read_n;
		logic                        write_n;
		logic                        bhe_n;
		logic                        hb_wr_n;
		logic                        lb_wr_n;
		logic                        ucs_n;
		logic                        lcs_n;
		logic                        mcs0_n;
		logic                        ucas_n;
		logic                        lcas_n;
		logic                        mid_memory_select_3_n_n;
		logic [`NUM_PCS-1:0]         pcs_n;
		logic                        done;
		data_type                    rdata;
		data_type                    wdata;
	} biu_state_type;

endpackage

/* File: cs_decoder.sv */
// Purpose: Address decode of the six memory and eight peripheral selects
// Assumes: Config inputs are stable while a cycle is decoded
// Notes:   Purely combinational; the bus sequencer registers its answer
`timescale 1ns/1ns
module cs_decoder
(
	// Cycle being decoded
	input  wire biu_pkg::addr_type          addr,
	input  wire logic                       io_cycle,
	// Select configuration
	input  wire biu_pkg::cs_vec_type        written,
	input  wire logic [9:0]                 upper_base,
	input  wire logic [9:0]                 lower_limit,
	input  wire logic [9:0]                 mid_base,
	input  wire logic [2:0]                 mid_block_log2,
	input  wire logic [8:0]                 pcs_base,
	input  wire logic                       pcs_in_io,
	input  wire logic                       dram_low_en,
	input  wire logic                       dram_mid3_en,
	// Decode answer
	output      biu_pkg::cs_vec_type        hit,
	output      logic                       dram_hit
);
	import biu_pkg::*;
	logic [9:0] kb;
	logic [9:0] mid_off;
	logic [9:0] mid_idx;
	logic       pcs_hit;
	logic       cas_taken;

	// Memory ranges; a select never fires before its control is written
	always_comb begin
		kb        = addr[`ADDR_W-1:`KB_LSB];
		mid_off   = kb - mid_base;
		mid_idx   = mid_off >> mid_block_log2;
		cas_taken = dram_low_en | dram_mid3_en;
		hit       = '0;
		pcs_hit   = (addr[`ADDR_W-1:`PCS_BASE_LSB] == pcs_base) && (io_cycle == pcs_in_io);
		for (int i = 0; i < `NUM_PCS; i++) begin
			hit[`CS_PCS0+i] = pcs_hit && (addr[`PCS_BASE_LSB-1:`PCS_BLOCK_LSB] == i[2:0])
			                  && written[`CS_PCS0+i];
		end
		if (!io_cycle && !pcs_hit) begin
			hit[`CS_UPPER] = (kb >= upper_base) && written[`CS_UPPER];
			hit[`CS_LOWER] = (kb <= lower_limit) && !hit[`CS_UPPER] && written[`CS_LOWER];
			if (!hit[`CS_UPPER] && !hit[`CS_LOWER] && kb >= mid_base && mid_idx < 10'h004) begin
				for (int m = 0; m < 4; m++) begin
					hit[`CS_MID0+m] = (mid_idx[1:0] == m[1:0]) && written[`CS_MID0+m];
				end
			end
			// Column strobe pins are not plain selects while DRAM is fitted
			if (cas_taken) begin
				hit[`CS_MID1] = 1'b0;
				hit[`CS_MID2] = 1'b0;
			end
		end
		dram_hit = (hit[`CS_LOWER] && dram_low_en) || (hit[`CS_MID3] && dram_mid3_en);
	end

endmodule

/* File: bus_interface_unit.sv */
// Purpose: External bus sequencer with byte write enables, chip selects and EDO DRAM control
// Assumes: mclk is the bus half-phase clock; system_clock_output toggles on every rising mclk edge
// Notes:   One request at a time; refresh wins over a pending CPU or DMA request
`timescale 1ns/1ns

// Notes on behaviour
// - Address bus leads multiplexed address by half cycle
// - Byte writes are OR of enable and write
// - Byte writes timed with the write strobe
// - Read strobe low during every read
// - Only 16-bit EDO DRAM, two banks maximum
// - DRAM accesses run with zero wait states
// - Row then column on odd address pins
// - All row and column strobes made internally
// - Row strobes shared with lower and mid3 selects
// - Mid1 upper column, mid2 lower column strobe
// - CAS-before-RAS refresh with three wait states
// - Single DRAM accesses only, never bursts
// - Peripheral selects beat DRAM on overlap
// - Six memory selects, eight 256-byte peripheral selects
// - Per-select bit chooses ready sensing
// - Per-select programmable wait states
// - Selects fire for CPU and DMA cycles
// - Selects float when mastered; active once written
module bus_interface_unit
(
	// Clock and reset
	input  wire logic                       mclk,
	input  wire logic                       rst_n,
	// Internal request from CPU or DMA, held until done
	input  wire logic                       req_valid,
	input  wire logic                       req_write,
	input  wire logic                       req_io,
	input  wire logic                       req_dma,
	input  wire biu_pkg::addr_type          req_addr,
	input  wire logic                       req_bhe_n,
	input  wire biu_pkg::data_type          req_wdata,
	output      logic                       req_done,
	output      biu_pkg::data_type          req_rdata,
	// Select configuration
	input  wire logic                       cfg_write,
	input  wire logic [3:0]                 cfg_index,
	input  wire logic [9:0]                 upper_base,
	input  wire logic [9:0]                 lower_limit,
	input  wire logic [9:0]                 mid_base,
	input  wire logic [2:0]                 mid_block_log2,
	input  wire logic [8:0]                 pcs_base,
	input  wire logic                       pcs_in_io,
	input  wire logic [`NUM_CS*`WAIT_W-1:0] wait_states,
	input  wire logic [`NUM_CS-1:0]         ready_enable,
	input  wire logic                       dram_low_en,
	input  wire logic                       dram_mid3_en,
	// External bus
	input  wire logic                       bus_hold,
	input  wire logic                       ready,
	input  wire biu_pkg::data_type          ad_in,
	output      biu_pkg::data_type          ad_out,
	output      logic                       ad_oe,
	output      biu_pkg::addr_type          addr_out,
	output      logic                       pins_oe,
	output      logic                       ale,
	output      logic                       system_clock_output,
	output      logic                       read_n,
	output      logic                       write_n,
	output      logic                       byte_high_enable_n,
	output      logic                       high_byte_write_n,
	output      logic                       low_byte_write_n,
	// Chip selects, floated with pins_oe
	output      logic                       upper_memory_select_n,
	output      logic                       lower_memory_select_n,
	output      logic                       mid_memory_select_0_n,
	output      logic                       upper_column_strobe_n,
	output      logic                       lower_column_strobe_n,
	output      logic                       mid_memory_select_3_n,
	output      logic [`NUM_PCS-1:0]        peripheral_select_n
);
	import biu_pkg::*;

	localparam int REFRESH_LAST = `REFRESH_CYCLES - 1;

	biu_state_type s_reg;
	biu_state_type s_next;
	cs_vec_type    dec_hit;
	logic          dec_dram;

	// Put a 9-bit DRAM half address on the odd address pins, A1 first
	function automatic addr_type dram_pins(input addr_type base, input logic [`DRAM_HALF_W-1:0] v);
		addr_type a;
		a = base;
		for (int i = 0; i < `DRAM_HALF_W; i++) begin
			a[2*i+1] = v[i];
		end
		return a;
	endfunction

	// Wait-state field of the selected region
	function automatic wait_type pick_wait(input cs_vec_type h, input logic [`NUM_CS*`WAIT_W-1:0] w);
		wait_type r;
		r = '0;
		for (int i = 0; i < `NUM_CS; i++) begin
			if (h[i]) begin
				r = w[i*`WAIT_W +: `WAIT_W];
			end
		end
		return r;
	endfunction

	// Decode of the incoming request address
	cs_decoder u_dec (
		.addr           (req_addr),
		.io_cycle       (req_io),
		.written        (s_reg.written),
		.upper_base     (upper_base),
		.lower_limit    (lower_limit),
		.mid_base       (mid_base),
		.mid_block_log2 (mid_block_log2),
		.pcs_base       (pcs_base),
		.pcs_in_io      (pcs_in_io),
		.dram_low_en    (dram_low_en),
		.dram_mid3_en   (dram_mid3_en),
		.hit            (dec_hit),
		.dram_hit       (dec_dram)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bus sequencer; each T-state spans two mclk cycles, one system_clock_output period
	always_comb begin
		logic phase_end;
		logic ref_wrap;
		logic start_ref;
		logic last_wait;
		logic [17:0] waddr;
		s_next    = s_reg;
		phase_end = s_reg.clk_out;
		ref_wrap  = (s_reg.ref_cnt == REFRESH_LAST[`REF_CNT_W-1:0]);
		start_ref = 1'b0;
		last_wait = (s_reg.wait_cnt == 4'h0) && !(s_reg.cur_rdy_en && !ready);
		waddr     = s_reg.cur_addr[18:1];

		s_next.clk_out = ~s_reg.clk_out;
		s_next.done    = 1'b0;
		s_next.ale     = 1'b0;

		// Configuration write activates a select; reading never does
		if (cfg_write && cfg_index < 4'hE) begin
			s_next.written[cfg_index] = 1'b1;
		end

		// Refresh timer; a new request sticks even in the cycle one is taken
		s_next.ref_cnt = ref_wrap ? '0 : s_reg.ref_cnt + 1'b1;

		unique case (s_reg.state)
			ST_IDLE: begin
				s_next.pins_oe = !bus_hold;
				if (phase_end && !bus_hold) begin
					if (s_reg.ref_pend) begin
						start_ref            = 1'b1;
						s_next.state         = ST_T1;
						s_next.cur_refresh   = 1'b1;
						s_next.cur_dram      = 1'b1;
						s_next.cur_write     = 1'b0;
						s_next.cur_rdy_en    = 1'b0;
						s_next.wait_cnt      = `REFRESH_WAIT_STATES;
					end else if (req_valid) begin
						// Same path for CPU and DMA cycles
						s_next.state         = ST_T1;
						s_next.cur_refresh   = 1'b0;
						s_next.cur_dram      = dec_dram;
						s_next.cur_write     = req_write;
						s_next.cur_addr      = req_addr;
						s_next.cur_bhe_n     = req_bhe_n;
						s_next.cur_hit       = dec_hit;
						s_next.wdata         = req_wdata;
						s_next.bhe_n         = req_bhe_n;
						// DRAM at 40 ns ignores programmed waits and ready
						s_next.wait_cnt      = dec_dram ? `DRAM_WAIT_STATES : pick_wait(dec_hit, wait_states);
						s_next.cur_rdy_en    = dec_dram ? 1'b0 : |(dec_hit & ready_enable);
						// Address bus valid at T1 entry, before the AD address
						s_next.addr_out      = dec_dram ? dram_pins(req_addr, req_addr[18:10]) : req_addr;
						s_next.ucs_n         = !dec_hit[`CS_UPPER];
						s_next.lcs_n         = !(dec_hit[`CS_LOWER] && !dec_dram);
						s_next.mcs0_n        = !dec_hit[`CS_MID0];
						s_next.ucas_n        = !dec_hit[`CS_MID1];
						s_next.lcas_n        = !dec_hit[`CS_MID2];
						s_next.mid_memory_select_3_n_n        = !(dec_hit[`CS_MID3] && !dec_dram);
						s_next.pcs_n         = ~dec_hit[`CS_PCS0 +: `NUM_PCS];
					end
				end
			end
			ST_T1: begin
				if (!phase_end) begin
					// Second half of T1: address onto AD, half a cycle after the A bus
					s_next.ad_out = s_reg.cur_addr[`DATA_W-1:0];
					s_next.ad_oe  = 1'b1;
					s_next.ale    = 1'b1;
				end else begin
					s_next.state = ST_T2;
					if (s_reg.cur_refresh) begin
						// CAS before RAS on both bytes
						s_next.ucas_n = 1'b0;
						s_next.lcas_n = 1'b0;
						s_next.ad_oe  = 1'b0;
					end else begin
						s_next.ad_out  = s_reg.wdata;
						s_next.ad_oe   = s_reg.cur_write;
						s_next.read_n  = s_reg.cur_write;
						s_next.write_n = !s_reg.cur_write;
						if (s_reg.cur_dram) begin
							// Row strobe on the bank's shared select pin
							s_next.lcs_n  = !s_reg.cur_hit[`CS_LOWER];
							s_next.mid_memory_select_3_n_n = !s_reg.cur_hit[`CS_MID3];
						end
					end
				end
			end
			ST_T2: begin
				if (phase_end) begin
					s_next.state = ST_T3;
					if (s_reg.cur_refresh) begin
						s_next.lcs_n  = !dram_low_en;
						s_next.mid_memory_select_3_n_n = !dram_mid3_en;
					end else if (s_reg.cur_dram) begin
						s_next.addr_out = dram_pins(s_reg.addr_out, waddr[8:0]);
						s_next.ucas_n   = s_reg.cur_bhe_n;
						s_next.lcas_n   = s_reg.cur_addr[0];
					end
				end
			end
			ST_T3, ST_TW: begin
				if (phase_end) begin
					if (s_reg.wait_cnt != 4'h0) begin
						s_next.state    = ST_TW;
						s_next.wait_cnt = s_reg.wait_cnt - 4'h1;
					end else if (!last_wait) begin
						s_next.state = ST_TW;
					end else begin
						s_next.state = ST_T4;
						s_next.rdata = ad_in;
						s_next.done  = !s_reg.cur_refresh;
						// Single access: every strobe ends here, no burst follows
						s_next.read_n  = 1'b1;
						s_next.write_n = 1'b1;
						s_next.ad_oe   = 1'b0;
						s_next.ucs_n   = 1'b1;
						s_next.lcs_n   = 1'b1;
						s_next.mcs0_n  = 1'b1;
						s_next.ucas_n  = 1'b1;
						s_next.lcas_n  = 1'b1;
						s_next.mid_memory_select_3_n_n  = 1'b1;
						s_next.pcs_n   = '1;
					end
				end
			end
			ST_T4: begin
				if (phase_end) begin
					s_next.state       = ST_IDLE;
					s_next.cur_refresh = 1'b0;
					s_next.bhe_n       = 1'b1;
				end
			end
		endcase

		// Refresh request survives a same-cycle take
		s_next.ref_pend = (ref_wrap && (dram_low_en || dram_mid3_en)) || (s_reg.ref_pend && !start_ref);

		// Byte writes registered with the write strobe, from the next strobes
		s_next.hb_wr_n = s_next.bhe_n | s_next.write_n;
		s_next.lb_wr_n = s_next.cur_addr[0] | s_next.write_n;
		if (s_next.cur_refresh) begin
			s_next.hb_wr_n = 1'b1;
			s_next.lb_wr_n = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_reg          <= '0;
			s_reg.state    <= ST_IDLE;
			s_reg.read_n   <= 1'b1;
			s_reg.write_n  <= 1'b1;
			s_reg.bhe_n    <= 1'b1;
			s_reg.hb_wr_n  <= 1'b1;
			s_reg.lb_wr_n  <= 1'b1;
			s_reg.ucs_n    <= 1'b1;
			s_reg.lcs_n    <= 1'b1;
			s_reg.mcs0_n   <= 1'b1;
			s_reg.ucas_n   <= 1'b1;
			s_reg.lcas_n   <= 1'b1;
			s_reg.mid_memory_select_3_n_n   <= 1'b1;
			s_reg.pcs_n    <= '1;
			s_reg.cur_bhe_n <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign req_done              = s_reg.done;
	assign req_rdata             = s_reg.rdata;
	assign ad_out                = s_reg.ad_out;
	assign ad_oe                 = s_reg.ad_oe;
	assign addr_out              = s_reg.addr_out;
	assign pins_oe               = s_reg.pins_oe;
	assign ale                   = s_reg.ale;
	assign system_clock_output   = s_reg.clk_out;
	assign read_n                = s_reg.read_n;
	assign write_n               = s_reg.write_n;
	assign byte_high_enable_n    = s_reg.bhe_n;
	assign high_byte_write_n     = s_reg.hb_wr_n;
	assign low_byte_write_n      = s_reg.lb_wr_n;
	assign upper_memory_select_n = s_reg.ucs_n;
	assign lower_memory_select_n = s_reg.lcs_n;
	assign mid_memory_select_0_n = s_reg.mcs0_n;
	assign upper_column_strobe_n = s_reg.ucas_n;
	assign lower_column_strobe_n = s_reg.lcas_n;
	assign mid_memory_select_3_n = s_reg.mid_memory_select_3_n_n;
	assign peripheral_select_n   = s_reg.pcs_n;

endmodule

/* File: biu_sva.sv */
// Purpose: Port level timing checks of the bus interface unit
// Assumes: Ports as the unit declares them
// Notes:   Attached by the bind at the foot of this file
`timescale 1ns/1ns
`include "biu_regs.svh"
module biu_sva (
	// Clock and reset
	input wire logic                mclk,
	input wire logic                rst_n,
	// Configuration seen by the unit
	input wire logic                dram_low_en,
	input wire logic                dram_mid3_en,
	// Bus pins
	input wire logic                req_done,
	input wire biu_pkg::data_type   ad_out,
	input wire logic                ad_oe,
	input wire biu_pkg::addr_type   addr_out,
	input wire logic                pins_oe,
	input wire logic                ale,
	input wire logic                read_n,
	input wire logic                write_n,
	input wire logic                byte_high_enable_n,
	input wire logic                high_byte_write_n,
	input wire logic                low_byte_write_n,
	// Selects and strobes
	input wire logic                lower_memory_select_n,
	input wire logic                upper_column_strobe_n,
	input wire logic                lower_column_strobe_n,
	input wire logic                mid_memory_select_3_n,
	input wire logic [`NUM_PCS-1:0] peripheral_select_n
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// DRAM remaps the address pins, so linear checks need both banks off
	wire plain = !dram_low_en && !dram_mid3_en;
	////////////////////////////////////////
	addr_lead_a: assert property (plain && ale |-> ad_oe && ad_out == addr_out[15:0] && $stable(addr_out))
		else $error("address bus did not lead the multiplexed address");
	addr_hold_a: assert property (plain && !high_byte_write_n |-> $stable(addr_out))
		else $error("address moved under a byte write");
	high_write_a: assert property (pins_oe |-> high_byte_write_n == (byte_high_enable_n | write_n))
		else $error("high byte write not the OR of enable and write");
	low_write_a: assert property (pins_oe && plain |-> low_byte_write_n == (addr_out[0] | write_n))
		else $error("low byte write not the OR of A0 and write");
	read_only_a: assert property (!read_n |-> write_n && high_byte_write_n && low_byte_write_n)
		else $error("write strobe during a read");
	float_quiet_a: assert property (!pins_oe |-> !ale && !ad_oe)
		else $error("bus activity while floated");
	pcs_first_a: assert property (pins_oe && peripheral_select_n != 8'hFF |->
		lower_memory_select_n && mid_memory_select_3_n && $onehot0(~peripheral_select_n))
		else $error("DRAM strobe beside a peripheral select");
	dram_zero_a: assert property ($fell(lower_memory_select_n) && !read_n |-> ##4 req_done)
		else $error("DRAM read not finished without waits");
	cbr_hold_a: assert property ($fell(lower_memory_select_n) && !lower_column_strobe_n |->
		(!lower_memory_select_n)[*6])
		else $error("refresh row strobe too short");
	single_cas_a: assert property ($rose(lower_column_strobe_n) |-> lower_memory_select_n)
		else $error("column strobe cycled within one row strobe");
	// Main scenarios reached
	cover property ($fell(lower_column_strobe_n) && lower_memory_select_n);
	cover property (!peripheral_select_n[0]);
	cover property (!high_byte_write_n && low_byte_write_n);
endmodule
bind bus_interface_unit biu_sva biu_sva_inst (.mclk, .rst_n, .dram_low_en, .dram_mid3_en, .req_done, .ad_out,
	.ad_oe, .addr_out, .pins_oe, .ale, .read_n, .write_n, .byte_high_enable_n, .high_byte_write_n,
	.low_byte_write_n, .lower_memory_select_n, .upper_column_strobe_n, .lower_column_strobe_n,
	.mid_memory_select_3_n, .peripheral_select_n);

/* File: ext_memory.sv */
// Purpose: Behavioural memory and peripheral on the external bus
// Assumes: Word index from address pins 6..1 in every mode
// Notes:   Slow mode holds ready low for a few cycles per strobe
`timescale 1ns/1ns
module ext_memory (
	// Clock and mode
	input wire logic              mclk,
	input wire logic              slow,
	// Bus from the unit
	input wire biu_pkg::addr_type addr_out,
	input wire biu_pkg::data_type ad_out,
	input wire logic              read_n,
	input wire logic              write_n,
	input wire logic              high_byte_write_n,
	input wire logic              low_byte_write_n,
	// Answers
	output biu_pkg::data_type     ad_in,
	output logic                  ready
);
	biu_pkg::data_type mem [0:63];
	biu_pkg::data_type last = 16'h0000;
	int stall = 0;
	// Byte lanes stored apart; stall always runs out so a cycle never hangs
	always @(posedge mclk) begin
		if (!high_byte_write_n) mem[addr_out[6:1]][15:8] <= ad_out[15:8];
		if (!low_byte_write_n) mem[addr_out[6:1]][7:0] <= ad_out[7:0];
		if (!read_n) last <= mem[addr_out[6:1]];
		if (read_n && write_n) stall <= slow ? 4 : 0;
		else if (stall > 0) stall <= stall - 1;
	end
	assign ready = (stall == 0);
	// Released lines show the inverse of the last word, never a held value
	assign ad_in = !read_n ? mem[addr_out[6:1]] : ~last;
endmodule

/* File: tb_bus_interface_unit.sv */
// Purpose: Self-checking bench of the bus interface unit
// Assumes: Memory model answers every access
// Notes:   Latency counted from the address latch pulse to done
`timescale 1ns/1ns
module tb_bus_interface_unit;
	import biu_pkg::*;
	logic mclk, rst_n, req_valid, req_write, req_io, req_dma, req_bhe_n, req_done, cfg_write, pcs_in_io;
	logic dram_low_en, dram_mid3_en, bus_hold, ready, slow, ad_oe, pins_oe, ale, system_clock_output;
	logic read_n, write_n, byte_high_enable_n, high_byte_write_n, low_byte_write_n, rd_seen, cbr_seen;
	logic upper_memory_select_n, lower_memory_select_n, mid_memory_select_0_n, upper_column_strobe_n;
	logic lower_column_strobe_n, mid_memory_select_3_n;
	addr_type req_addr, addr_out, row_seen, col_seen;
	data_type req_wdata, req_rdata, ad_in, ad_out;
	logic [3:0] cfg_index;
	logic [9:0] upper_base, lower_limit, mid_base;
	logic [2:0] mid_block_log2;
	logic [8:0] pcs_base;
	logic [`NUM_CS*`WAIT_W-1:0] wait_states;
	logic [`NUM_CS-1:0] ready_enable, low_seen;
	logic [`NUM_PCS-1:0] peripheral_select_n;
	logic [1:0] wr_seen;
	int fail_count, tests_run, n;
	////////////////////////////////////////
	bus_interface_unit bus_interface_unit_inst (.mclk, .rst_n, .req_valid, .req_write, .req_io, .req_dma,
		.req_addr, .req_bhe_n, .req_wdata, .req_done, .req_rdata, .cfg_write, .cfg_index, .upper_base,
		.lower_limit, .mid_base, .mid_block_log2, .pcs_base, .pcs_in_io, .wait_states, .ready_enable,
		.dram_low_en, .dram_mid3_en, .bus_hold, .ready, .ad_in, .ad_out, .ad_oe, .addr_out, .pins_oe, .ale,
		.system_clock_output, .read_n, .write_n, .byte_high_enable_n, .high_byte_write_n, .low_byte_write_n,
		.upper_memory_select_n, .lower_memory_select_n, .mid_memory_select_0_n, .upper_column_strobe_n,
		.lower_column_strobe_n, .mid_memory_select_3_n, .peripheral_select_n);
	ext_memory ext_memory_inst (.mclk, .slow, .addr_out, .ad_out, .read_n, .write_n, .high_byte_write_n,
		.low_byte_write_n, .ad_in, .ready);
	initial begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	// Sticky record of one access; floated pins are ignored
	always @(posedge mclk) begin
		if (pins_oe) begin
			low_seen <= low_seen | ~{peripheral_select_n, mid_memory_select_3_n, lower_column_strobe_n,
				upper_column_strobe_n, mid_memory_select_0_n, lower_memory_select_n, upper_memory_select_n};
			wr_seen <= wr_seen | ~{high_byte_write_n, low_byte_write_n};
			rd_seen <= rd_seen | !read_n;
			if (!lower_memory_select_n && upper_column_strobe_n && lower_column_strobe_n) row_seen <= addr_out;
			if (!lower_memory_select_n && !lower_column_strobe_n) col_seen <= addr_out;
			if (lower_memory_select_n && !lower_column_strobe_n && !upper_column_strobe_n) cbr_seen <= 1'b1;
		end
	end
	////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One bus cycle held until done; n counts from the latch pulse
	task automatic access(input logic wr, input addr_type a, input logic bn, input data_type wd);
		int k = 0;
		n = 0;
		low_seen = '0;
		wr_seen = '0;
		rd_seen = 0;
		req_write = wr;
		req_addr = a;
		req_bhe_n = bn;
		req_wdata = wd;
		req_valid = 1;
		while (req_done !== 1'b1 && k < 200) begin
			@(posedge mclk);
			#1;
			k++;
			n = ale ? 0 : n + 1;
		end
		if (k >= 200) check("done", 0, 1);
		req_valid = 0;
		@(posedge mclk);
		#1;
	endtask
	////////////////////////////////////////
	task automatic t_config;
		access(0, 20'hF0010, 0, 0);
		check("unwritten selects", low_seen, 0);
		check("read strobe", rd_seen, 1);
		cfg_write = 1;
		for (int i = 0; i < `NUM_CS; i++) begin
			cfg_index = i[3:0];
			@(posedge mclk);
			#1;
		end
		cfg_write = 0;
		$display("config test done");
	endtask
	task automatic t_bytes;
		logic [21:0] tab [3] = '{{20'h40010, 2'b00}, {20'h40011, 2'b01}, {20'h40010, 2'b10}};
		data_type wd [3] = '{16'hA5C3, 16'h7E00, 16'h0011};
		for (int i = 0; i < 3; i++) begin
			req_dma = i[0];
			access(1, tab[i][21:2], tab[i][1], wd[i]);
			check("byte writes", wr_seen, {!tab[i][1], !tab[i][2]});
			check("mid select", low_seen, 14'h0004);
		end
		access(0, 20'h40010, 0, 0);
		check("read back", req_rdata, 16'h7E11);
		$display("bytes test done");
	endtask
	task automatic t_waits;
		slow = 1;
		access(0, 20'hF0020, 0, 0);
		check("wait latency", n, 9);
		check("upper select", low_seen, 14'h0001);
		slow = 0;
		$display("waits test done");
	endtask
	task automatic t_dram;
		dram_low_en = 1;
		slow = 1;
		access(1, 20'h0A246, 0, 16'hBEEF);
		access(0, 20'h0A246, 0, 0);
		check("dram data", req_rdata, 16'hBEEF);
		check("dram latency", n, 5);
		check("dram strobes", low_seen, 14'h001A);
		check("row", row_seen & 20'h2AAAA, 20'h00880);
		check("column", col_seen & 20'h2AAAA, 20'h2080A);
		access(0, 20'h0A246, 1, 0);
		check("low byte cas", low_seen, 14'h0012);
		$display("dram test done");
	endtask
	task automatic t_ready;
		access(0, 20'h08000, 0, 0);
		check("ready stall", n, 7);
		check("pcs beats dram", low_seen, 14'h0040);
		slow = 0;
		access(0, 20'h08100, 0, 0);
		check("ready prompt", n, 5);
		check("second pcs", low_seen, 14'h0080);
		$display("ready test done");
	endtask
	task automatic t_refresh;
		cbr_seen = 0;
		for (int k = 0; k < 3200 && !cbr_seen; k++) @(posedge mclk);
		#1;
		check("cbr refresh", cbr_seen, 1);
		$display("refresh test done");
	endtask
	task automatic t_hold;
		bus_hold = 1;
		repeat (12) @(posedge mclk);
		#1;
		check("floated", pins_oe, 0);
		bus_hold = 0;
		repeat (2) @(posedge mclk);
		#1;
		check("driven again", pins_oe, 1);
		$display("hold test done");
	endtask
	////////////////////////////////////////
	initial begin
		{rst_n, req_valid, req_write, req_io, req_dma, req_bhe_n, cfg_write, pcs_in_io} = '0;
		{dram_low_en, dram_mid3_en, bus_hold, slow, rd_seen, cbr_seen} = '0;
		{req_addr, req_wdata, cfg_index, low_seen, wr_seen, row_seen, col_seen} = '0;
		{fail_count, tests_run, n} = '0;
		upper_base = 10'h3C0;
		lower_limit = 10'h03F;
		mid_base = 10'h100;
		mid_block_log2 = 3'h3;
		pcs_base = 9'h010;
		wait_states = 56'h2;
		ready_enable = 14'h00C0;
		repeat (5) @(posedge mclk);
		#1;
		rst_n = 1;
		t_config();
		t_bytes();
		t_waits();
		t_dram();
		t_ready();
		t_refresh();
		t_hold();
		conclude();
	end
	// Hang guard well past the refresh interval
	initial begin
		repeat (8000) @(posedge mclk);
		fail_count++;
		conclude();
	end
endmodule
